// file: hdl/pmc_mode_control_decode.sv
// Mode, sense, range, clamp and limit-flag decode for the measurement unit
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// - One shared 16-bit reference level code, full range 0x0000 to 0xffff.
// - Reset loads the shared reference level code with 0x4000.
// - Sense select 0 routes internal pin path, 1 routes external sense input.
// - Sense goes to ground in high-voltage drive or idle mode automatically.
// - Mode derives from low-leak input, force high-Z, force and measure bits.
// - Force output high-Z when force high-Z bit or low-leak input is 0.
// - Force high-Z bit resets to 0, output starts in low leakage.
// - Measure output enabled only when bit and input both 1; bit resets 0.
// - Comparator enable bit 0 puts both limit flags in high impedance.
// - Enabled limit flags follow the window truth table of both thresholds.
// - Measure bit picks voltage or current; sense bit picks voltage source.
// - Clamp bit 1 enables voltage and current clamps, 0 disables them.
// - Voltage clamps act only in force-current mode, watching pin voltage.
// - Current clamps act only in force-voltage mode.
// - Range letters A to E select 20, 500, 5k, 50k, 500k ohms.
// - Any force-nothing mode leaves the force output high impedance.
// - Feedback and measure selectors plus force high-Z give six modes.
// - Shared external force and sense switches each have their own bit.
// - In force high-Z modes a requested range A becomes range B.
module pmc_mode_control_decode #(
	parameter int CH_N = 2
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic [CH_N-1:0] lowLeakPinInput,
	input wire logic [CH_N-1:0] measureHighzInput,
	input wire logic [CH_N-1:0] pinVoltAboveUpper,
	input wire logic [CH_N-1:0] pinVoltAboveLower,
	input wire logic [CH_N-1:0] extVoltAboveUpper,
	input wire logic [CH_N-1:0] extVoltAboveLower,
	input wire logic [CH_N-1:0] currAboveUpper,
	input wire logic [CH_N-1:0] currAboveLower,
	output logic [15:0] currentReferenceLevel,
	output logic externalForceSwitch,
	output logic externalSenseSwitch,
	output logic [CH_N-1:0][5:0] unitMode,
	output logic [CH_N-1:0] forceOutEnable,
	output logic [CH_N-1:0] feedbackIsCurrent,
	output logic [CH_N-1:0] measureOutEnable,
	output logic [CH_N-1:0] measureIsVoltage,
	output logic [CH_N-1:0] senseToInternal,
	output logic [CH_N-1:0] senseToExternal,
	output logic [CH_N-1:0] senseToGround,
	output logic [CH_N-1:0] voltageClampEnable,
	output logic [CH_N-1:0] currentClampEnable,
	output logic [CH_N-1:0][2:0] rangeSelect,
	output logic [CH_N-1:0] upperLimitFlagOut,
	output logic [CH_N-1:0] upperLimitFlagOe,
	output logic [CH_N-1:0] lowerLimitFlagOut,
	output logic [CH_N-1:0] lowerLimitFlagOe
);

	initial begin
		if (CH_N < 1 || CH_N > 16) begin
			$error("CH_N must lie between 1 and 16");
		end
	end

	typedef struct packed {
		logic [CH_N-1:0][15:0] ctl;
		logic [15:0] refCode;
		logic [1:0] sw;
		logic [15:0] rdata;
		logic refTouched;
		logic [CH_N-1:0][5:0] mode;
		logic [CH_N-1:0] forceEn;
		logic [CH_N-1:0] fbCurrent;
		logic [CH_N-1:0] measEn;
		logic [CH_N-1:0] measVolt;
		logic [CH_N-1:0] senseInt;
		logic [CH_N-1:0] senseExt;
		logic [CH_N-1:0] senseGnd;
		logic [CH_N-1:0] vClamp;
		logic [CH_N-1:0] iClamp;
		logic [CH_N-1:0][2:0] range;
		logic [CH_N-1:0] upperOe;
		logic [CH_N-1:0] lowerOe;
	} pmc_state_s;

	pmc_state_s q;
	pmc_state_s d;

	// Mode decode from the low-leak input and the control word
	function automatic pmc_pkg::pmc_mode_e decodeMode(input logic [15:0] c, input logic llk);
		logic forcing;
		logic calForceV;
		forcing = llk && c[pmc_pkg::F_FORCE_HIGHZ];
		calForceV = llk && !c[pmc_pkg::F_FORCE_HIGHZ] && !c[pmc_pkg::F_FORCE_KIND];
		if (forcing && c[pmc_pkg::F_FORCE_KIND]) begin
			return c[pmc_pkg::F_MEASURE_KIND] ? pmc_pkg::MODE_CURRENT_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_CURRENT_FORCE_CURRENT_MEASURE;
		end else if (forcing || calForceV) begin
			return c[pmc_pkg::F_MEASURE_KIND] ? pmc_pkg::MODE_VOLTAGE_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_VOLTAGE_FORCE_CURRENT_MEASURE;
		end else begin
			return c[pmc_pkg::F_MEASURE_KIND] ? pmc_pkg::MODE_NO_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE;
		end
	endfunction

	// Range letter from the three select bits
	function automatic logic [2:0] decodeRange(input logic [15:0] c, input logic llk);
		logic [2:0] rs;
		rs = c[pmc_pkg::F_RANGE_LO +: 3];
		case (rs)
			3'h0: return pmc_pkg::RANGE_E;
			3'h1: return pmc_pkg::RANGE_D;
			3'h2: return pmc_pkg::RANGE_C;
			3'h3: return pmc_pkg::RANGE_B;
			default: begin
				// Force high-Z demotes A to B
				// range A fallback
				if (llk && c[pmc_pkg::F_FORCE_HIGHZ]) begin
					return pmc_pkg::RANGE_A;
				end
				return pmc_pkg::RANGE_B;
			end
		endcase
	endfunction

	always_comb begin
		pmc_pkg::pmc_mode_e m;
		logic [15:0] c;
		logic aboveU;
		logic aboveL;
		logic forceNothing;
		m = pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE;
		c = '0;
		aboveU = 1'b0;
		aboveL = 1'b0;
		forceNothing = 1'b0;
		d = q;
		d.rdata = '0;
		if (regWr) begin
			for (int i = 0; i < CH_N; i++) begin
				if (regAddr == pmc_pkg::CTL_BASE + 8'(i)) begin
					d.ctl[i] = regWdata;
				end
			end
			if (regAddr == pmc_pkg::REF_ADDR) begin
				d.refCode = regWdata;
				d.refTouched = 1'b1;
			end
			if (regAddr == pmc_pkg::SW_ADDR) begin
				d.sw = regWdata[1:0];
			end
		end
		if (regRd) begin
			for (int i = 0; i < CH_N; i++) begin
				if (regAddr == pmc_pkg::CTL_BASE + 8'(i)) begin
					d.rdata = q.ctl[i];
				end
				if (regAddr == pmc_pkg::STAT_BASE + 8'(i)) begin
					d.rdata[pmc_pkg::S_MODE_LO +: 6] = q.mode[i];
					d.rdata[pmc_pkg::S_FORCE_EN] = q.forceEn[i];
					d.rdata[pmc_pkg::S_MEASURE_OUTPUT_EN] = q.measEn[i];
					d.rdata[pmc_pkg::S_UPPER] = q.upperOe[i];
					d.rdata[pmc_pkg::S_LOWER] = q.lowerOe[i];
					d.rdata[pmc_pkg::S_RANGE_LO +: 3] = q.range[i];
				end
			end
			if (regAddr == pmc_pkg::REF_ADDR) begin
				d.rdata = q.refCode;
			end
			if (regAddr == pmc_pkg::SW_ADDR) begin
				d.rdata[1:0] = q.sw;
			end
		end
		for (int i = 0; i < CH_N; i++) begin
			c = q.ctl[i];
			m = decodeMode(c, lowLeakPinInput[i]);
			d.mode[i] = m;
			forceNothing = (m == pmc_pkg::MODE_NO_FORCE_VOLTAGE_MEASURE) || (m == pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE);
			d.forceEn[i] = lowLeakPinInput[i] && c[pmc_pkg::F_FORCE_HIGHZ] && !forceNothing;
			d.fbCurrent[i] = (m == pmc_pkg::MODE_CURRENT_FORCE_VOLTAGE_MEASURE) || (m == pmc_pkg::MODE_CURRENT_FORCE_CURRENT_MEASURE);
			d.measEn[i] = c[pmc_pkg::F_MEASURE_HIGHZ] && measureHighzInput[i];
			d.measVolt[i] = c[pmc_pkg::F_MEASURE_KIND];
			// automatic ground
			// Grounding shields the amplifier from overvoltage glitches
			d.senseGnd[i] = c[pmc_pkg::F_HV_MODE] || (m == pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE);
			d.senseInt[i] = !d.senseGnd[i] && !c[pmc_pkg::F_SENSE_SEL];
			d.senseExt[i] = !d.senseGnd[i] && c[pmc_pkg::F_SENSE_SEL];
			d.vClamp[i] = c[pmc_pkg::F_CLAMP_ON] && d.fbCurrent[i] && d.forceEn[i];
			d.iClamp[i] = c[pmc_pkg::F_CLAMP_ON] && !d.fbCurrent[i] && !forceNothing;
			d.range[i] = decodeRange(c, lowLeakPinInput[i]);
			if (!c[pmc_pkg::F_MEASURE_KIND]) begin
				aboveU = currAboveUpper[i];
				aboveL = currAboveLower[i];
			end else if (c[pmc_pkg::F_SENSE_SEL]) begin
				aboveU = extVoltAboveUpper[i];
				aboveL = extVoltAboveLower[i];
			end else begin
				aboveU = pinVoltAboveUpper[i];
				aboveL = pinVoltAboveLower[i];
			end
			d.upperOe[i] = c[pmc_pkg::F_COMP_ON] && aboveU;
			d.lowerOe[i] = c[pmc_pkg::F_COMP_ON] && !aboveL;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.refCode <= pmc_pkg::REF_RESET;
			for (int i = 0; i < CH_N; i++) begin
				q.mode[i] <= pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE;
				q.senseGnd[i] <= 1'b1;
				q.range[i] <= pmc_pkg::RANGE_E;
			end
		end else begin
			q <= d;
		end
	end

	assign regRdata = q.rdata;
	assign currentReferenceLevel = q.refCode;
	assign externalForceSwitch = q.sw[pmc_pkg::W_EXT_FORCE];
	assign externalSenseSwitch = q.sw[pmc_pkg::W_EXT_SENSE];
	assign unitMode = q.mode;
	assign forceOutEnable = q.forceEn;
	assign feedbackIsCurrent = q.fbCurrent;
	assign measureOutEnable = q.measEn;
	assign measureIsVoltage = q.measVolt;
	assign senseToInternal = q.senseInt;
	assign senseToExternal = q.senseExt;
	assign senseToGround = q.senseGnd;
	assign voltageClampEnable = q.vClamp;
	assign currentClampEnable = q.iClamp;
	assign rangeSelect = q.range;
	assign upperLimitFlagOut = '0;
	assign upperLimitFlagOe = q.upperOe;
	assign lowerLimitFlagOut = '0;
	assign lowerLimitFlagOe = q.lowerOe;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_refWrite;
		regWr && regAddr == pmc_pkg::REF_ADDR;
	endsequence
	sequence s_refRead;
		regRd && regAddr == pmc_pkg::REF_ADDR;
	endsequence

	property p_refReadBack;
		s_refWrite ##1 (s_refRead and !regWr) |=> regRdata == $past(regWdata, 2);
	endproperty
	a_refReadBack: assert property (p_refReadBack) else $error("Reference code read back wrong");

	property p_refReset;
		!q.refTouched |-> currentReferenceLevel == pmc_pkg::REF_RESET;
	endproperty
	a_refReset: assert property (p_refReset) else $error("Reference code not at reset value");

	property p_senseRoute;
		!q.ctl[0][pmc_pkg::F_HV_MODE] && decodeMode(q.ctl[0], lowLeakPinInput[0]) != pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE
			|=> senseToExternal[0] == $past(q.ctl[0][pmc_pkg::F_SENSE_SEL]) && !senseToGround[0];
	endproperty
	a_senseRoute: assert property (p_senseRoute) else $error("Sense routing mismatch");

	property p_senseGround;
		q.ctl[0][pmc_pkg::F_HV_MODE]
			|| decodeMode(q.ctl[0], lowLeakPinInput[0]) == pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE
			|=> senseToGround[0] && !senseToInternal[0] && !senseToExternal[0];
	endproperty
	a_senseGround: assert property (p_senseGround) else $error("Sense not grounded");

	property p_forceGate;
		!(q.ctl[0][pmc_pkg::F_FORCE_HIGHZ] && lowLeakPinInput[0]) |=> !forceOutEnable[0];
	endproperty
	a_forceGate: assert property (p_forceGate) else $error("Force output not high-Z");

	property p_modeForcing;
		lowLeakPinInput[0] && q.ctl[0][pmc_pkg::F_FORCE_HIGHZ] |=> forceOutEnable[0]
			&& feedbackIsCurrent[0] == $past(q.ctl[0][pmc_pkg::F_FORCE_KIND]);
	endproperty
	a_modeForcing: assert property (p_modeForcing) else $error("Forcing mode wrong");

	property p_measGate;
		measureOutEnable[0] |-> $past(q.ctl[0][pmc_pkg::F_MEASURE_HIGHZ] && measureHighzInput[0]);
	endproperty
	a_measGate: assert property (p_measGate) else $error("Measure output enabled wrongly");

	property p_flagsOff;
		!q.ctl[0][pmc_pkg::F_COMP_ON] ##1 !q.ctl[0][pmc_pkg::F_COMP_ON]
			|=> !upperLimitFlagOe[0] && !lowerLimitFlagOe[0];
	endproperty
	a_flagsOff: assert property (p_flagsOff) else $error("Limit flags driven while disabled");

	property p_flagsBetween;
		q.ctl[0][pmc_pkg::F_COMP_ON] && !q.ctl[0][pmc_pkg::F_MEASURE_KIND]
			&& !currAboveUpper[0] && currAboveLower[0] |=> !upperLimitFlagOe[0] && !lowerLimitFlagOe[0];
	endproperty
	a_flagsBetween: assert property (p_flagsBetween) else $error("In-window flags wrong");

	property p_voltClamp;
		voltageClampEnable[0] |-> $past(q.ctl[0][pmc_pkg::F_CLAMP_ON]) && feedbackIsCurrent[0];
	endproperty
	a_voltClamp: assert property (p_voltClamp) else $error("Voltage clamp outside FI");

	property p_rangeDemote;
		q.ctl[0][pmc_pkg::F_RANGE_LO + 2] && !q.ctl[0][pmc_pkg::F_FORCE_HIGHZ]
			|=> rangeSelect[0] == pmc_pkg::RANGE_B;
	endproperty
	a_rangeDemote: assert property (p_rangeDemote) else $error("Range A in high-Z mode");

	property p_rdataIdle;
		!regRd |=> regRdata == 16'h0000;
	endproperty
	a_rdataIdle: assert property (p_rdataIdle) else $error("Read data not idle");

	property p_clampOff;
		!q.ctl[0][pmc_pkg::F_CLAMP_ON] |=> !voltageClampEnable[0] && !currentClampEnable[0];
	endproperty
	a_clampOff: assert property (p_clampOff) else $error("Clamp on while disabled");

	property p_currClamp;
		currentClampEnable[0] |-> $past(q.ctl[0][pmc_pkg::F_CLAMP_ON])
			&& (unitMode[0] == pmc_pkg::MODE_VOLTAGE_FORCE_CURRENT_MEASURE || unitMode[0] == pmc_pkg::MODE_VOLTAGE_FORCE_VOLTAGE_MEASURE);
	endproperty
	a_currClamp: assert property (p_currClamp) else $error("Current clamp outside FV");

	property p_rangeDirect;
		q.ctl[0][pmc_pkg::F_RANGE_LO +: 3] == 3'h0 |=> rangeSelect[0] == pmc_pkg::RANGE_E;
	endproperty
	a_rangeDirect: assert property (p_rangeDirect) else $error("Range E not selected");

endmodule
`default_nettype wire

// file: hdl/pmc_pkg.sv
// Shared constants and types for the measurement-unit mode control decode
package pmc_pkg;

	// Register word indices on the plain register port
	localparam logic [7:0] CTL_BASE = 8'h00;
	localparam logic [7:0] STAT_BASE = 8'h10;
	localparam logic [7:0] REF_ADDR = 8'h20;
	localparam logic [7:0] SW_ADDR = 8'h21;

	// Per-channel control word fields
	localparam int F_FORCE_KIND = 0;
	localparam int F_MEASURE_KIND = 1;
	localparam int F_SENSE_SEL = 2;
	localparam int F_FORCE_HIGHZ = 3;
	localparam int F_MEASURE_HIGHZ = 4;
	localparam int F_COMP_ON = 5;
	localparam int F_CLAMP_ON = 6;
	localparam int F_RANGE_LO = 7;
	localparam int F_HV_MODE = 10;

	// Per-channel status word fields
	localparam int S_MODE_LO = 0;
	localparam int S_FORCE_EN = 6;
	localparam int S_MEASURE_OUTPUT_EN = 7;
	localparam int S_UPPER = 8;
	localparam int S_LOWER = 9;
	localparam int S_RANGE_LO = 10;

	// Shared switch word fields
	localparam int W_EXT_FORCE = 0;
	localparam int W_EXT_SENSE = 1;

	// Reset values and reference code limits
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] REF_RESET = 16'h4000;
	localparam logic [15:0] REF_MIN = 16'h0000;
	localparam logic [15:0] REF_MAX = 16'hffff;

	// Range select codes and their resistor values in ohms
	localparam logic [2:0] RANGE_A = 3'h0;
	localparam logic [2:0] RANGE_B = 3'h1;
	localparam logic [2:0] RANGE_C = 3'h2;
	localparam logic [2:0] RANGE_D = 3'h3;
	localparam logic [2:0] RANGE_E = 3'h4;
	localparam int OHM_A = 20;
	localparam int OHM_B = 500;
	localparam int OHM_C = 5000;
	localparam int OHM_D = 50000;
	localparam int OHM_E = 500000;

	typedef enum logic [5:0] {
		MODE_VOLTAGE_FORCE_CURRENT_MEASURE = 6'h01,
		MODE_CURRENT_FORCE_VOLTAGE_MEASURE = 6'h02,
		MODE_VOLTAGE_FORCE_VOLTAGE_MEASURE = 6'h04,
		MODE_CURRENT_FORCE_CURRENT_MEASURE = 6'h08,
		MODE_NO_FORCE_VOLTAGE_MEASURE = 6'h10,
		MODE_IDLE_NO_FORCE_NO_MEASURE = 6'h20
	} pmc_mode_e;

endpackage

// file: test/pmc_host_model.sv
// Host model driving the register port and the per-pin logic inputs
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model #(
	parameter int CH_N = 2
) (
	input wire logic core_clk,
	output var logic [7:0] regAddr,
	output var logic [15:0] regWdata,
	output var logic regWr,
	output var logic regRd,
	input wire logic [15:0] regRdata,
	output var logic [CH_N-1:0] lowLeak,
	output var logic [CH_N-1:0] measHighz,
	output var logic [CH_N-1:0] pinUp,
	output var logic [CH_N-1:0] pinLo,
	output var logic [CH_N-1:0] extUp,
	output var logic [CH_N-1:0] extLo,
	output var logic [CH_N-1:0] curUp,
	output var logic [CH_N-1:0] curLo
);
	initial {regAddr, regWdata, regWr, regRd} = '0;
	initial {lowLeak, measHighz, pinUp, pinLo, extUp, extLo, curUp, curLo} = '0;

	// Idle bus shows inverted values so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdata;
	endtask

	// Write then read with no gap between the strobes
	task automatic wrrd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] rv);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
		#1;
		rv = regRdata;
	endtask

	task automatic drive(input logic [CH_N-1:0] ll, mh, pu, pl, eu, el, cu, cl);
		@(posedge core_clk);
		lowLeak <= ll;
		measHighz <= mh;
		pinUp <= pu;
		pinLo <= pl;
		extUp <= eu;
		extLo <= el;
		curUp <= cu;
		curLo <= cl;
	endtask
endmodule
`default_nettype wire

// file: test/pmc_mode_control_decode_tb_top.sv
// Self-checking testbench for the measurement-unit mode control decode
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_control_decode_tb_top;
	localparam int CH = 2;
	logic coreClk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, refLevel, rdv;
	logic regWr, regRd, extForce, extSense;
	logic [CH-1:0] lowLeak, measHighz, pinUp, pinLo, extUp, extLo, curUp, curLo;
	logic [CH-1:0][5:0] unitMode;
	logic [CH-1:0][2:0] rangeSel;
	logic [CH-1:0] forceEn, fbCur, measEn, measVolt, sInt, sExt, sGnd;
	logic [CH-1:0] vClamp, iClamp, upOut, upOe, loOut, loOe;
	logic [12:0] st0, st1;
	int mismatches = 0;
	int numChecks = 0;
	int cycleCount = 0;

	always #4 coreClk = ~coreClk;

	pmc_host_model #(.CH_N(CH)) u_host (.core_clk(coreClk), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.lowLeak(lowLeak), .measHighz(measHighz), .pinUp(pinUp), .pinLo(pinLo),
		.extUp(extUp), .extLo(extLo), .curUp(curUp), .curLo(curLo));

	pmc_mode_control_decode #(.CH_N(CH)) u_dut (.core_clk(coreClk), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .lowLeakPinInput(lowLeak), .measureHighzInput(measHighz),
		.pinVoltAboveUpper(pinUp), .pinVoltAboveLower(pinLo), .extVoltAboveUpper(extUp),
		.extVoltAboveLower(extLo), .currAboveUpper(curUp), .currAboveLower(curLo),
		.currentReferenceLevel(refLevel), .externalForceSwitch(extForce),
		.externalSenseSwitch(extSense), .unitMode(unitMode), .forceOutEnable(forceEn),
		.feedbackIsCurrent(fbCur), .measureOutEnable(measEn), .measureIsVoltage(measVolt),
		.senseToInternal(sInt), .senseToExternal(sExt), .senseToGround(sGnd),
		.voltageClampEnable(vClamp), .currentClampEnable(iClamp), .rangeSelect(rangeSel),
		.upperLimitFlagOut(upOut), .upperLimitFlagOe(upOe), .lowerLimitFlagOut(loOut),
		.lowerLimitFlagOe(loOe));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Decode is registered behind the register write
	task automatic settle();
		repeat (3) @(posedge coreClk);
		#1;
	endtask

	task automatic chk_ch(input int c, input logic [10:0] w, input logic ll, mh, a, b,
		output logic [12:0] st);
		logic fo, gnd, up, lo;
		logic [5:0] m;
		logic [2:0] r;
		fo = ll & w[3];
		if (fo && w[0])
			m = w[1] ? pmc_pkg::MODE_CURRENT_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_CURRENT_FORCE_CURRENT_MEASURE;
		else if (fo || (ll && !w[0]))
			m = w[1] ? pmc_pkg::MODE_VOLTAGE_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_VOLTAGE_FORCE_CURRENT_MEASURE;
		else
			m = w[1] ? pmc_pkg::MODE_NO_FORCE_VOLTAGE_MEASURE : pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE;
		gnd = w[10] | (m == pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE);
		r = w[9] ? (fo ? pmc_pkg::RANGE_A : pmc_pkg::RANGE_B) : 3'h4 - {1'b0, w[8:7]};
		// Other sources get different levels so a wrong pick shows
		{up, lo} = w[1] ? (w[2] ? {~a, ~b} : {a, b}) : {b, ~a};
		st = {r, w[5] & ~lo, w[5] & up, w[4] & mh, fo, m};
		check(16'(unitMode[c]), 16'(m));
		check(16'(forceEn[c]), 16'(fo));
		check(16'(fbCur[c]), 16'(m[1] | m[3]));
		check(16'(measEn[c]), 16'(w[4] & mh));
		check(16'({sGnd[c], sExt[c], sInt[c]}), 16'({gnd, ~gnd & w[2], ~gnd & ~w[2]}));
		check(16'({vClamp[c], iClamp[c]}), 16'({w[6] & m[1] | w[6] & m[3],
			w[6] & m[0] | w[6] & m[2]}));
		check(16'(rangeSel[c]), 16'(r));
		check(16'({measVolt[c], upOe[c], loOe[c], upOut[c], loOut[c]}),
			16'({w[1], w[5] & up, w[5] & ~lo, 2'b00}));
	endtask

	task automatic scen_reset();
		check(refLevel, pmc_pkg::REF_RESET);
		check(16'(unitMode), 16'({2{pmc_pkg::MODE_IDLE_NO_FORCE_NO_MEASURE}}));
		check(16'({forceEn, measEn, sGnd, extForce, extSense}), 16'h000c);
		u_host.wr(pmc_pkg::STAT_BASE, 16'hffff);
		u_host.wr(8'h30, 16'h1234);
		u_host.rd(pmc_pkg::STAT_BASE, rdv);
		check(rdv, 16'h1020);
		u_host.rd(8'h30, rdv);
		check(rdv, 16'h0000);
		u_host.rd(pmc_pkg::REF_ADDR, rdv);
		check(rdv, pmc_pkg::REF_RESET);
	endtask

	task automatic scen_ref_sw();
		logic [15:0] val;
		for (int i = 0; i < 3; i++) begin
			val = (i == 0) ? pmc_pkg::REF_MAX : (i == 1) ? pmc_pkg::REF_MIN : 16'h1234;
			u_host.wr(pmc_pkg::REF_ADDR, val);
			u_host.rd(pmc_pkg::REF_ADDR, rdv);
			check(rdv, val);
			check(refLevel, val);
		end
		for (int s = 0; s < 4; s++) begin
			u_host.wr(pmc_pkg::SW_ADDR, 16'(s));
			u_host.rd(pmc_pkg::SW_ADDR, rdv);
			check(rdv, 16'(s));
			check(16'({extSense, extForce}), 16'(s));
		end
	endtask

	task automatic scen_decode();
		logic [10:0] w;
		logic [1:0] ll, mh, a, b;
		for (int v = 0; v < 2048; v++) begin
			w = 11'(v);
			ll = {w[5] ^ w[9], w[4] ^ w[8]};
			mh = {w[1], w[0] ^ w[9]};
			a = {w[2], w[1] ^ w[6]};
			b = {w[7] ^ w[0], w[3] ^ w[8]};
			u_host.wr(pmc_pkg::CTL_BASE, 16'(w));
			u_host.wr(pmc_pkg::CTL_BASE + 8'h01, 16'(~w));
			u_host.drive(ll, mh, a, b, ~a, ~b, b, ~a);
			settle();
			chk_ch(0, w, ll[0], mh[0], a[0], b[0], st0);
			chk_ch(1, ~w, ll[1], mh[1], a[1], b[1], st1);
			u_host.rd(pmc_pkg::STAT_BASE + 8'h01, rdv);
			check(rdv, {3'h0, st1});
		end
	endtask

	// Reset in mid-run with forcing and switches active
	task automatic scen_midreset();
		u_host.wr(pmc_pkg::CTL_BASE, 16'h0049);
		u_host.drive(2'b01, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00);
		settle();
		check(16'({forceEn, vClamp}), 16'h0005);
		@(posedge coreClk);
		rstn <= 1'b0;
		#1;
		check(refLevel, pmc_pkg::REF_RESET);
		check(16'({forceEn, vClamp, extForce, extSense}), 16'h0000);
		@(posedge coreClk);
		rstn <= 1'b1;
		@(posedge coreClk);
		#1;
		// Low-leak input still high, cleared control gives calibration FV
		check(16'(unitMode[0]), 16'(pmc_pkg::MODE_VOLTAGE_FORCE_CURRENT_MEASURE));
		check(16'({forceEn, sInt}), 16'h0001);
		u_host.wrrd(pmc_pkg::REF_ADDR, 16'h5a5a, rdv);
		check(rdv, 16'h5a5a);
		@(posedge coreClk);
		#1;
		check(regRdata, 16'h0000);
	endtask

	initial begin
		repeat (3) @(posedge coreClk);
		rstn <= 1'b1;
		#1;
		scen_reset();
		scen_ref_sw();
		scen_decode();
		scen_midreset();
		complete_run();
	end

	always @(posedge coreClk) begin
		cycleCount++;
		if (cycleCount == 40000) begin
			mismatches++;
			complete_run();
		end
	end
endmodule
`default_nettype wire
